// File: hdl/spfc_self_program_flash_control.sv
// self-program flash control: command register, arming window, flash op sequencing
//
// How it works
// R1: ready request while enable irq and store idle
// R2: erase/write to lower section sets busy flag
// R3: busy flag clears on reenable or buffer fill
// R4: reenable command works only when no operation
// R5: reenable during buffer loading discards loaded data
// R6: lock set command programs boot lock bits
// R7: load within three cycles returns lock/fuse
// R8: page write command writes buffer to page
// R9: halt cpu for upper section page operations
// R10: page erase command erases selected page
// R11: enable alone stores word into buffer
// R12: enable arms four cycles, held during operation
// R13: other command patterns have no effect
// R14: reserved control bit reads as zero
// R15: boot size fuses set boot start address
// R16: pages 224 up form halting section
// R17: page from z14..z7, word from z6..z1
// R18: software keeps word bits zero for write
// R19: z15 ignored, z0 byte select for load
// R20: lower section unreadable during erase or write
// R21: software waits idle before new command
// R22: eeprom write blocks commands and fuse reads
// R23: operations last the programming time
// R24: new write restarts window, timeout clears all
//
// Our own choices: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ns
module spfc_self_program_flash_control #(
    parameter int unsigned PROG_CYCLES = spfc_pkg::PROG_CYCLES_DEF
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [spfc_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [spfc_pkg::ADDR_W-1:0] s_axi_araddr,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    input wire logic spmReq,
    input wire logic lpmReq,
    input wire logic [15:0] zPointer,
    input wire logic [7:0] regR0,
    input wire logic [7:0] regR1,
    input wire logic globalIrqEnable,
    input wire logic eeprom_write_active,
    input wire logic [7:0] fuseLow,
    input wire logic [7:0] fuseHigh,
    output logic storeReadyIrq,
    output logic cpuHalt,
    output logic rwwBlocked,
    output logic bufWrite,
    output logic [5:0] bufWord,
    output logic [15:0] bufData,
    output logic bufDiscard,
    output logic flashStart,
    output logic [1:0] flashOp,
    output logic [7:0] flashPage,
    output logic lpmValid,
    output logic [7:0] lpmData,
    output logic [7:0] lockBits,
    output logic [13:0] bootStart,
    output logic [13:0] appEnd
);

    typedef struct packed {
        logic awready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic irqEn;
        logic busyFlag;
        logic [spfc_pkg::CMD_W-1:0] cmd;
        logic [2:0] armCnt;
        spfc_pkg::spfc_op_state_type op;
        logic [1:0] opKind;
        logic [spfc_pkg::CNT_W-1:0] opCnt;
        logic cpuHalt;
        logic bufLoaded;
        logic [7:0] lockBits;
        logic [1:0] bootFuse;
        logic bufWrite;
        logic [5:0] bufWord;
        logic [15:0] bufData;
        logic bufDiscard;
        logic flashStart;
        logic [7:0] flashPage;
        logic lpmValid;
        logic [7:0] lpmData;
        logic irqReq;
        logic [13:0] bootStart;
        logic [13:0] appEnd;
    } spfc_state_type;

    spfc_state_type q;
    spfc_state_type d;

    ////////////////////////////////////////////////////////////////////////
    // command and boot size fuse decode helpers

    function automatic logic valid_cmd(input logic [spfc_pkg::CMD_W-1:0] c);
        logic ok;
        ok = 1'b0;
        unique case (c)
            spfc_pkg::CMD_REENABLE,
            spfc_pkg::CMD_LOCK,
            spfc_pkg::CMD_PWRITE,
            spfc_pkg::CMD_ERASE,
            spfc_pkg::CMD_FILL: begin
                ok = 1'b1;
            end
            default: begin
                ok = 1'b0;
            end
        endcase
        return ok;
    endfunction

    function automatic logic [13:0] boot_start_of(input logic [1:0] fuse);
        logic [13:0] s;
        s = spfc_pkg::BOOT_START_2K;
        unique case (fuse)
            2'h3: s = spfc_pkg::BOOT_START_256;
            2'h2: s = spfc_pkg::BOOT_START_512;
            2'h1: s = spfc_pkg::BOOT_START_1K;
            2'h0: s = spfc_pkg::BOOT_START_2K;
        endcase
        return s;
    endfunction

    logic armed;
    logic [7:0] ctrlByte;
    logic [7:0] pageSel;
    logic [spfc_pkg::CNT_W-1:0] progLoad;

    assign progLoad = spfc_pkg::CNT_W'(PROG_CYCLES - 1);
    // R17 page field
    assign pageSel = zPointer[spfc_pkg::Z_PAGE_HI:spfc_pkg::Z_PAGE_LO];
    // R14 reserved bit zero
    assign ctrlByte = {q.irqEn, q.busyFlag, 1'b0, q.cmd};
    assign armed = q.cmd[0] && (q.op == spfc_pkg::OP_IDLE) && (q.armCnt != 3'h0);

    ////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        d = q;
        d.bufWrite = 1'b0;
        d.bufDiscard = 1'b0;
        d.flashStart = 1'b0;
        d.lpmValid = 1'b0;

        // R24 timeout clears all
        if (armed) begin
            d.armCnt = q.armCnt - 3'h1;
            if (q.armCnt == 3'h1) begin
                d.cmd = spfc_pkg::CMD_NONE;
            end
        end

        // R22 eeprom blocks store
        if (spmReq && armed && !eeprom_write_active) begin
            d.armCnt = 3'h0;
            unique case (q.cmd)
                spfc_pkg::CMD_FILL: begin
                    // R11 buffer word store
                    d.bufWrite = 1'b1;
                    d.bufWord = zPointer[spfc_pkg::Z_WORD_HI:spfc_pkg::Z_WORD_LO];
                    d.bufData = {regR1, regR0};
                    d.bufLoaded = 1'b1;
                    // R3 fill clears busy
                    d.busyFlag = 1'b0;
                    d.cmd = spfc_pkg::CMD_NONE;
                end
                spfc_pkg::CMD_ERASE,
                spfc_pkg::CMD_PWRITE: begin
                    // R10 R8 start page operation
                    d.op = spfc_pkg::OP_BUSY;
                    d.opCnt = progLoad;
                    d.flashStart = 1'b1;
                    d.flashPage = pageSel;
                    d.opKind = (q.cmd == spfc_pkg::CMD_ERASE) ? spfc_pkg::OP_ERASE : spfc_pkg::OP_WRITE;
                    if (q.cmd == spfc_pkg::CMD_PWRITE) begin
                        d.bufLoaded = 1'b0;
                    end
                    // R16 section split
                    if (pageSel < spfc_pkg::HALTING_SECTION_FIRST_PAGE) begin
                        // R2 busy flag set
                        d.busyFlag = 1'b1;
                    end else begin
                        // R9 halt cpu
                        d.cpuHalt = 1'b1;
                    end
                end
                spfc_pkg::CMD_LOCK: begin
                    // R6 program boot lock bits
                    d.lockBits[spfc_pkg::LOCK_BOOT_HI:spfc_pkg::LOCK_BOOT_LO] =
                        q.lockBits[spfc_pkg::LOCK_BOOT_HI:spfc_pkg::LOCK_BOOT_LO] &
                        regR0[spfc_pkg::LOCK_BOOT_HI:spfc_pkg::LOCK_BOOT_LO];
                    d.op = spfc_pkg::OP_BUSY;
                    d.opCnt = progLoad;
                    d.flashStart = 1'b1;
                    d.opKind = spfc_pkg::OP_LOCK;
                end
                spfc_pkg::CMD_REENABLE: begin
                    // R4 unblock section
                    d.busyFlag = 1'b0;
                    d.cmd = spfc_pkg::CMD_NONE;
                end
                default: begin
                    d.cmd = q.cmd;
                end
            endcase
        end

        // R7 lock or fuse read in a shorter window
        if (lpmReq && armed && (q.cmd == spfc_pkg::CMD_LOCK) && !eeprom_write_active
            && (q.armCnt > (spfc_pkg::ARM_CYCLES - spfc_pkg::LPM_CYCLES))) begin
            d.lpmValid = 1'b1;
            // R19 z0 clear reads fuse low, else z1 picks fuse high or lock
            if (zPointer[spfc_pkg::Z_BYTE]) begin
                d.lpmData = zPointer[spfc_pkg::Z_HIGH_SEL] ? fuseHigh : q.lockBits;
            end else begin
                d.lpmData = fuseLow;
            end
            d.cmd = spfc_pkg::CMD_NONE;
            d.armCnt = 3'h0;
        end

        // R23 programming time
        unique case (q.op)
            spfc_pkg::OP_IDLE: begin
                d.op = d.op;
            end
            spfc_pkg::OP_BUSY: begin
                if (q.opCnt == '0) begin
                    d.op = spfc_pkg::OP_FINISH;
                end else begin
                    d.opCnt = q.opCnt - spfc_pkg::CNT_W'(1);
                end
            end
            spfc_pkg::OP_FINISH: begin
                // R12 enable held until done
                d.op = spfc_pkg::OP_IDLE;
                d.cmd = spfc_pkg::CMD_NONE;
                d.cpuHalt = 1'b0;
            end
            default: begin
                d.op = spfc_pkg::OP_IDLE;
            end
        endcase

        ////////////////////////////////////////////////////////////////////
        // register bus write
        d.awready = 1'b0;
        if (q.bvalid && s_axi_bready) begin
            d.bvalid = 1'b0;
        end
        if (s_axi_awvalid && s_axi_wvalid && !q.awready && !q.bvalid) begin
            d.awready = 1'b1;
            d.bvalid = 1'b1;
            d.bresp = spfc_pkg::RESP_OKAY;
            unique case ({s_axi_awaddr[spfc_pkg::ADDR_W-1:2], 2'b00})
                spfc_pkg::ADDR_CTRL: begin
                    if (s_axi_wstrb[0]) begin
                        d.irqEn = s_axi_wdata[spfc_pkg::BIT_IRQ_EN];
                        // R13 R22 only legal patterns, idle, no eeprom write
                        if (valid_cmd(s_axi_wdata[spfc_pkg::CMD_W-1:0]) && !eeprom_write_active
                            && (q.op == spfc_pkg::OP_IDLE)) begin
                            d.cmd = s_axi_wdata[spfc_pkg::CMD_W-1:0];
                            // R24 window restart
                            d.armCnt = spfc_pkg::ARM_CYCLES;
                            // R5 abort partial load
                            if ((s_axi_wdata[spfc_pkg::CMD_W-1:0] == spfc_pkg::CMD_REENABLE)
                                && q.bufLoaded) begin
                                d.bufDiscard = 1'b1;
                                d.bufLoaded = 1'b0;
                            end
                        end
                    end
                end
                spfc_pkg::ADDR_CFG: begin
                    if (s_axi_wstrb[0]) begin
                        d.bootFuse = s_axi_wdata[1:0];
                    end
                end
                spfc_pkg::ADDR_STATUS: begin
                    d.bresp = spfc_pkg::RESP_OKAY;
                end
                default: begin
                    d.bresp = spfc_pkg::RESP_SLVERR;
                end
            endcase
        end

        ////////////////////////////////////////////////////////////////////
        // register bus read
        d.arready = 1'b0;
        if (q.rvalid && s_axi_rready) begin
            d.rvalid = 1'b0;
        end
        if (s_axi_arvalid && !q.arready && !q.rvalid) begin
            d.arready = 1'b1;
            d.rvalid = 1'b1;
            d.rresp = spfc_pkg::RESP_OKAY;
            d.rdata = 32'h0000_0000;
            unique case ({s_axi_araddr[spfc_pkg::ADDR_W-1:2], 2'b00})
                spfc_pkg::ADDR_CTRL: begin
                    d.rdata[7:0] = ctrlByte;
                end
                spfc_pkg::ADDR_CFG: begin
                    d.rdata[1:0] = q.bootFuse;
                end
                spfc_pkg::ADDR_STATUS: begin
                    d.rdata[spfc_pkg::STAT_OP] = (q.op != spfc_pkg::OP_IDLE);
                    d.rdata[spfc_pkg::STAT_HALT] = q.cpuHalt;
                    d.rdata[spfc_pkg::STAT_LOADED] = q.bufLoaded;
                    d.rdata[spfc_pkg::STAT_LOCK_LO+7:spfc_pkg::STAT_LOCK_LO] = q.lockBits;
                end
                default: begin
                    d.rresp = spfc_pkg::RESP_SLVERR;
                end
            endcase
        end

        // R1 ready request while store idle
        d.irqReq = q.irqEn && globalIrqEnable && !q.cmd[0];
        // R15 boot partition
        d.bootStart = boot_start_of(d.bootFuse);
        d.appEnd = d.bootStart - 14'h0001;
    end

    ////////////////////////////////////////////////////////////////////////
    // state register

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            q <= '0;
            q.lockBits <= spfc_pkg::LOCK_RESET;
            q.bootFuse <= spfc_pkg::CFG_RESET;
            q.bootStart <= spfc_pkg::BOOT_START_2K;
            q.appEnd <= spfc_pkg::BOOT_START_2K - 14'h0001;
        end else begin
            q <= d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs, all straight from the state register

    assign s_axi_awready = q.awready;
    assign s_axi_wready = q.awready;
    assign s_axi_bvalid = q.bvalid;
    assign s_axi_bresp = q.bresp;
    assign s_axi_arready = q.arready;
    assign s_axi_rvalid = q.rvalid;
    assign s_axi_rdata = q.rdata;
    assign s_axi_rresp = q.rresp;
    assign storeReadyIrq = q.irqReq;
    assign cpuHalt = q.cpuHalt;
    // R20 lower section blocked while busy
    assign rwwBlocked = q.busyFlag;
    assign bufWrite = q.bufWrite;
    assign bufWord = q.bufWord;
    assign bufData = q.bufData;
    assign bufDiscard = q.bufDiscard;
    assign flashStart = q.flashStart;
    assign flashOp = q.opKind;
    assign flashPage = q.flashPage;
    assign lpmValid = q.lpmValid;
    assign lpmData = q.lpmData;
    assign lockBits = q.lockBits;
    assign bootStart = q.bootStart;
    assign appEnd = q.appEnd;

endmodule

// File: pkg/spfc_pkg.sv
// constants and types for the self-program flash control block
package spfc_pkg;
    // register map, byte addresses on the register bus
    localparam int ADDR_W = 4;
    localparam logic [ADDR_W-1:0] ADDR_CTRL = 4'h0;
    localparam logic [ADDR_W-1:0] ADDR_CFG = 4'h4;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 4'h8;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // program_store_control bit positions
    localparam int BIT_IRQ_EN = 7;
    localparam int BIT_BUSY = 6;
    localparam int CMD_W = 5;

    // command patterns in the low five control bits
    localparam logic [CMD_W-1:0] CMD_REENABLE = 5'h11;
    localparam logic [CMD_W-1:0] CMD_LOCK = 5'h09;
    localparam logic [CMD_W-1:0] CMD_PWRITE = 5'h05;
    localparam logic [CMD_W-1:0] CMD_ERASE = 5'h03;
    localparam logic [CMD_W-1:0] CMD_FILL = 5'h01;
    localparam logic [CMD_W-1:0] CMD_NONE = 5'h00;

    // config register: boot size fuse pair in bits 1:0
    localparam logic [1:0] CFG_RESET = 2'h0;

    // status register bit positions
    localparam int STAT_OP = 0;
    localparam int STAT_HALT = 1;
    localparam int STAT_LOADED = 2;
    localparam int STAT_LOCK_LO = 8;

    // arming windows in clock cycles
    localparam logic [2:0] ARM_CYCLES = 3'h4;
    localparam logic [2:0] LPM_CYCLES = 3'h3;

    // programming time, taken at its minimum and rounded up
    localparam int CLK_PERIOD_NS = 10;
    localparam int PROG_TIME_NS = 3700000;
    localparam int PROG_CYCLES_DEF = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 24;

    // z pointer fields
    localparam int Z_PAGE_HI = 14;
    localparam int Z_PAGE_LO = 7;
    localparam int Z_WORD_HI = 6;
    localparam int Z_WORD_LO = 1;
    localparam int Z_BYTE = 0;
    localparam int Z_HIGH_SEL = 1;

    // flash layout
    localparam logic [7:0] HALTING_SECTION_FIRST_PAGE = 8'he0;
    localparam logic [13:0] BOOT_START_256 = 14'h3f00;
    localparam logic [13:0] BOOT_START_512 = 14'h3e00;
    localparam logic [13:0] BOOT_START_1K = 14'h3c00;
    localparam logic [13:0] BOOT_START_2K = 14'h3800;
    localparam logic [7:0] LOCK_RESET = 8'hff;
    localparam int LOCK_BOOT_HI = 5;
    localparam int LOCK_BOOT_LO = 2;

    localparam logic [1:0] OP_ERASE = 2'h1;
    localparam logic [1:0] OP_WRITE = 2'h2;
    localparam logic [1:0] OP_LOCK = 2'h3;

    typedef enum logic [1:0] {
        OP_IDLE = 2'b00,
        OP_BUSY = 2'b01,
        OP_FINISH = 2'b11
    } spfc_op_state_type;
endpackage

// File: tb/spfc_cpu_model.sv
// cpu core model: issues store and load instructions with their operands
`timescale 1ns/1ns
module spfc_cpu_model (
    input wire logic clk,
    output logic spmReq,
    output logic lpmReq,
    output logic [15:0] zPointer,
    output logic [7:0] regR0,
    output logic [7:0] regR1
);
    initial begin
        {spmReq, lpmReq} = 2'h0;
        {zPointer, regR0, regR1} = '0;
    end

    task automatic issue(input logic ld, input logic [15:0] z, input logic [7:0] r0, input logic [7:0] r1);
        zPointer <= ld ? z : {z[15:1], 1'b0};
        regR0 <= r0;
        regR1 <= r1;
        spmReq <= !ld;
        lpmReq <= ld;
        @(posedge clk);
        {spmReq, lpmReq} <= 2'h0;
        // operands are not held after the instruction, so they toggle
        zPointer <= ~z;
        regR0 <= ~r0;
        regR1 <= ~r1;
    endtask
endmodule

// File: tb/spfc_properties.sv
// concurrent checks on the ports of the self-program flash control block
`timescale 1ns/1ns
module spfc_properties #(
    parameter int unsigned PROG_CYCLES = 8
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [15:0] zPointer,
    input wire logic [7:0] regR0,
    input wire logic [7:0] regR1,
    input wire logic globalIrqEnable,
    input wire logic eeprom_write_active,
    input wire logic [7:0] fuseLow,
    input wire logic [7:0] fuseHigh,
    input wire logic storeReadyIrq,
    input wire logic cpuHalt,
    input wire logic rwwBlocked,
    input wire logic bufWrite,
    input wire logic [5:0] bufWord,
    input wire logic [15:0] bufData,
    input wire logic flashStart,
    input wire logic [1:0] flashOp,
    input wire logic [7:0] flashPage,
    input wire logic lpmValid,
    input wire logic [7:0] lpmData,
    input wire logic [7:0] lockBits
);
    logic [spfc_pkg::CNT_W-1:0] haltCnt_q;

    // counter instead of a long repetition, which would not scale with the real count
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            haltCnt_q <= '0;
        end else begin
            haltCnt_q <= cpuHalt ? haltCnt_q + 1'b1 : '0;
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);

    sequence s_op_start;
        flashStart && flashOp != spfc_pkg::OP_LOCK;
    endsequence
    sequence s_no_irq;
        !storeReadyIrq [*6];
    endsequence

    a_fill_word: assert property (bufWrite |->
        bufData == {$past(regR1), $past(regR0)} && bufWord == $past(zPointer[6:1])) else $error("buffer store wrong");
    a_fill_unblock: assert property (bufWrite |=> !rwwBlocked) else $error("fill left section blocked");
    a_page_select: assert property (s_op_start |-> flashPage == $past(zPointer[14:7]))
        else $error("page select wrong");
    a_rww_busy: assert property (s_op_start ##0 flashPage < spfc_pkg::HALTING_SECTION_FIRST_PAGE |=> rwwBlocked)
        else $error("busy flag not set");
    a_halting_section_halt: assert property (s_op_start ##0 flashPage >= spfc_pkg::HALTING_SECTION_FIRST_PAGE |=> cpuHalt)
        else $error("cpu not halted");
    a_irq_quiet: assert property (s_op_start |=> s_no_irq) else $error("ready request during operation");
    a_irq_gate: assert property (storeReadyIrq |-> $past(globalIrqEnable)) else $error("request while masked");
    a_halt_span: assert property ($fell(cpuHalt) |->
        haltCnt_q >= PROG_CYCLES && haltCnt_q <= PROG_CYCLES + 2) else $error("halt length wrong");
    a_lpm_select: assert property (lpmValid |-> lpmData ==
        ($past(zPointer[0]) ? ($past(zPointer[1]) ? $past(fuseHigh) : $past(lockBits)) : $past(fuseLow)))
        else $error("read-back byte wrong");
    a_eeprom_block: assert property ((lpmValid || flashStart) |-> !$past(eeprom_write_active))
        else $error("action during eeprom write");
endmodule

bind spfc_self_program_flash_control spfc_properties #(.PROG_CYCLES(PROG_CYCLES)) i_props (
    .clk, .rst_b, .zPointer, .regR0, .regR1, .globalIrqEnable, .eeprom_write_active, .fuseLow, .fuseHigh,
    .storeReadyIrq, .cpuHalt, .rwwBlocked, .bufWrite, .bufWord, .bufData, .flashStart, .flashOp,
    .flashPage, .lpmValid, .lpmData, .lockBits
);

// File: tb/tb.sv
// self-checking bench for the self-program flash control block
`timescale 1ns/1ns
module tb;
    logic clk, rst_b, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, spmReq, lpmReq, globalIrqEnable, cpuHalt;
    logic eeprom_write_active, storeReadyIrq, rwwBlocked, bufWrite, bufDiscard, flashStart, lpmValid;
    logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
    logic [31:0] s_axi_wdata, s_axi_rdata, v;
    logic [1:0] s_axi_bresp, s_axi_rresp, flashOp, resp;
    logic [15:0] zPointer, bufData;
    logic [7:0] regR0, regR1, fuseLow, fuseHigh, flashPage, lpmData, lockBits;
    logic [5:0] bufWord;
    logic [13:0] bootStart, appEnd;
    int failCount, numChecks, seed, i, lockM, irqM;

    spfc_self_program_flash_control #(.PROG_CYCLES(8)) i_dut (
        .clk, .rst_b, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
        .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp,
        .spmReq, .lpmReq, .zPointer, .regR0, .regR1, .globalIrqEnable, .eeprom_write_active, .fuseLow,
        .fuseHigh, .storeReadyIrq, .cpuHalt, .rwwBlocked, .bufWrite, .bufWord, .bufData, .bufDiscard,
        .flashStart, .flashOp, .flashPage, .lpmValid, .lpmData, .lockBits, .bootStart, .appEnd
    );
    spfc_cpu_model i_cpu (.clk, .spmReq, .lpmReq, .zPointer, .regR0, .regR1);

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic completeRun;
        if (failCount == 0 && numChecks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        numChecks++;
        if (g !== e) begin
            failCount++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        do begin
            @(posedge clk);
        end while (s_axi_bvalid !== 1'b1);
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h0;
        resp = s_axi_bresp;
    endtask

    // leading edge keeps back-to-back reads from assigning arvalid twice in one step
    task automatic rd(input string n, input logic [3:0] a, input logic [31:0] e);
        @(posedge clk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        do begin
            @(posedge clk);
        end while (s_axi_rvalid !== 1'b1);
        {s_axi_arvalid, s_axi_rready} <= 2'h0;
        v = s_axi_rdata;
        resp = s_axi_rresp;
        if (n != "") chk(n, e, v);
    endtask

    task automatic waitOp;
        for (int n = 0; n < 30; n++) begin
            rd("", spfc_pkg::ADDR_STATUS, 0);
            if (v[spfc_pkg::STAT_OP] === 1'b0) break;
        end
    endtask

    // this task puts irqM[0] in the interrupt enable bit, which is set from the erase test on
    task automatic cmd(input logic [4:0] c);
        wr(spfc_pkg::ADDR_CTRL, {24'h0, irqM[0], 2'h0, c});
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (5000) @(posedge clk);
        failCount++;
        completeRun();
    end

    initial begin
        seed = 52881;
        {failCount, numChecks, irqM} = '0;
        lockM = 255;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, globalIrqEnable} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, eeprom_write_active} = '0;
        s_axi_wstrb = 4'hf;
        v = $random(seed);
        {fuseHigh, fuseLow} = v[15:0];
        rst_b = 1'b0;
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        rd("ctrl", spfc_pkg::ADDR_CTRL, 0);
        rd("status", spfc_pkg::ADDR_STATUS, 32'hff00);
        rd("unmapped", 4'hc, 0);
        chk("rresp", 32'(spfc_pkg::RESP_SLVERR), 32'(resp));
        for (i = 0; i < 4; i++) begin
            wr(spfc_pkg::ADDR_CFG, i);
            repeat (2) @(posedge clk);
            chk("bootStart", 16384 - (2048 >> i), 32'(bootStart));
            chk("appEnd", 16383 - (2048 >> i), 32'(appEnd));
        end
        for (i = 0; i < 4; i++) begin
            v = $random(seed);
            cmd(spfc_pkg::CMD_FILL);
            repeat (i) @(posedge clk);
            i_cpu.issue(1'b0, v[31:16], v[7:0], v[15:8]);
            @(posedge clk);
            chk("bufWrite", i < 3, 32'(bufWrite));
            if (i < 3) begin
                chk("bufData", v[15:0], 32'(bufData));
                chk("bufWord", v[22:17], 32'(bufWord));
            end
        end
        for (i = 0; i < 3; i++) begin
            cmd(i == 0 ? 5'h1f : (i == 1 ? 5'h10 : 5'h07));
            i_cpu.issue(1'b0, 16'h0004, 8'h12, 8'h34);
            @(posedge clk);
            chk("bufWrite", 0, 32'(bufWrite));
            rd("ctrl", spfc_pkg::ADDR_CTRL, 0);
        end
        irqM = 1;
        globalIrqEnable <= 1'b1;
        cmd(spfc_pkg::CMD_ERASE);
        i_cpu.issue(1'b0, 16'h8280, 8'h5a, 8'ha5);
        @(posedge clk);
        chk("erase", {1'b1, 2'h1, 8'h05}, {flashStart, flashOp, flashPage});
        rd("ctrl", spfc_pkg::ADDR_CTRL, 32'hc3);
        cmd(spfc_pkg::CMD_REENABLE);
        chk("bufDiscard", 0, 32'(bufDiscard));
        i_cpu.issue(1'b0, 16'h0000, 8'h00, 8'h00);
        waitOp();
        rd("ctrl", spfc_pkg::ADDR_CTRL, 32'hc0);
        chk("irq", 1, 32'(storeReadyIrq));
        chk("rww", 1, 32'(rwwBlocked));
        globalIrqEnable <= 1'b0;
        repeat (2) @(posedge clk);
        chk("irq", 0, 32'(storeReadyIrq));
        cmd(spfc_pkg::CMD_REENABLE);
        chk("bufDiscard", 1, 32'(bufDiscard));
        i_cpu.issue(1'b0, 16'h0000, 8'h00, 8'h00);
        repeat (2) @(posedge clk);
        chk("rww", 0, 32'(rwwBlocked));
        rd("status", spfc_pkg::ADDR_STATUS, 32'hff00);
        cmd(spfc_pkg::CMD_ERASE);
        i_cpu.issue(1'b0, 16'h0300, 8'h00, 8'h00);
        waitOp();
        chk("rww", 1, 32'(rwwBlocked));
        cmd(spfc_pkg::CMD_FILL);
        i_cpu.issue(1'b0, 16'h0002, 8'h77, 8'h88);
        repeat (2) @(posedge clk);
        chk("rww", 0, 32'(rwwBlocked));
        cmd(spfc_pkg::CMD_PWRITE);
        i_cpu.issue(1'b0, 16'h7280, 8'h00, 8'h00);
        @(posedge clk);
        chk("write", {1'b1, 2'h2, 8'he5}, {flashStart, flashOp, flashPage});
        rd("status", spfc_pkg::ADDR_STATUS, 32'hff03);
        waitOp();
        chk("halt", 0, 32'(cpuHalt));
        rd("status", spfc_pkg::ADDR_STATUS, 32'hff00);
        v = $random(seed);
        cmd(spfc_pkg::CMD_LOCK);
        i_cpu.issue(1'b0, v[31:16], v[7:0], v[15:8]);
        lockM = lockM & {2'h3, v[5:2], 2'h3};
        @(posedge clk);
        chk("lockOp", {1'b1, spfc_pkg::OP_LOCK}, {flashStart, flashOp});
        waitOp();
        chk("lockBits", lockM, 32'(lockBits));
        for (i = 0; i < 3; i++) begin
            cmd(spfc_pkg::CMD_LOCK);
            i_cpu.issue(1'b1, 16'(i == 2 ? 3 : i), 8'h00, 8'h00);
            @(posedge clk);
            chk("lpmValid", 1, 32'(lpmValid));
            chk("lpmData", i == 0 ? fuseLow : (i == 1 ? lockM : fuseHigh), 32'(lpmData));
        end
        eeprom_write_active <= 1'b1;
        cmd(spfc_pkg::CMD_LOCK);
        i_cpu.issue(1'b1, 16'h0001, 8'h00, 8'h00);
        @(posedge clk);
        chk("lpmValid", 0, 32'(lpmValid));
        completeRun();
    end
endmodule
